// file: rtl/ioxc_pkg.sv
// Constants of the change-interrupt and configuration register bank.
// Assumes a single 200 MHz clock and a byte-wide register port from the protocol engine.
package ioxc_pkg;

  // ------------------------------------------------------------------
  // Register kinds: index of a register inside one port's bank
  // ------------------------------------------------------------------
  localparam logic [3:0] REG_DIRECTION = 4'h0;
  localparam logic [3:0] REG_POLARITY  = 4'h1;
  localparam logic [3:0] REG_IRQ_EN    = 4'h2;
  localparam logic [3:0] REG_DEFAULT   = 4'h3;
  localparam logic [3:0] REG_SOURCE    = 4'h4;
  localparam logic [3:0] REG_CONFIG    = 4'h5;
  localparam logic [3:0] REG_PULLUP    = 4'h6;
  localparam logic [3:0] REG_FLAG      = 4'h7;
  localparam logic [3:0] REG_CAPTURE   = 4'h8;
  localparam logic [3:0] REG_PORT      = 4'h9;
  localparam logic [3:0] REG_LATCH     = 4'hA;

  // ------------------------------------------------------------------
  // Address map limits
  // ------------------------------------------------------------------
  localparam logic [3:0] SPLIT_LAST_KIND  = 4'hA;
  localparam logic [7:0] PAIRED_LAST_ADDR = 8'h15;
  localparam int         SPLIT_PORT_BIT   = 4;

  // ------------------------------------------------------------------
  // Configuration register fields
  // ------------------------------------------------------------------
  localparam int         CFG_BANK_SPLIT  = 7;
  localparam int         CFG_MIRROR      = 6;
  localparam int         CFG_PTR_HOLD    = 5;
  localparam int         CFG_SLEW_OFF    = 4;
  localparam int         CFG_HW_ADDR_EN  = 3;
  localparam int         CFG_OPEN_DRAIN  = 2;
  localparam int         CFG_ACTIVE_HIGH = 1;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'hFE;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_PTR   = 8'h00;
  localparam logic [2:0] RST_ADDR  = 3'h0;
  localparam logic       RST_IRQ   = 1'b1;
  localparam logic       RST_IRQ_OE = 1'b1;

endpackage : ioxc_pkg

// file: rtl/ioxc_port_if.sv
// Per-port bundle between the register bank and one change detector.
// Assumes both ends run on the same clock.
interface ioxc_port_if;
  logic [7:0] enable;
  logic [7:0] dflt;
  logic [7:0] source;
  logic [7:0] is_input;
  logic [7:0] pins;
  logic       clear;
  logic       irq;
  logic [7:0] flags;
  logic [7:0] capture;

  modport bank (
    output enable,
    output dflt,
    output source,
    output is_input,
    output pins,
    output clear,
    input  irq,
    input  flags,
    input  capture
  );

  modport detect (
    input  enable,
    input  dflt,
    input  source,
    input  is_input,
    input  pins,
    input  clear,
    output irq,
    output flags,
    output capture
  );
endinterface : ioxc_port_if

// file: rtl/ioxc_addr_map.sv
// Address decoder for the split and paired register maps.
// Assumes the map select comes straight from the configuration register.
module ioxc_addr_map (
  input  wire logic [7:0] addr_i,
  input  wire logic       bank_split_i,
  output logic            valid_o,
  output logic [3:0]      kind_o,
  output logic            port_b_o
);

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  always_comb begin
    if (bank_split_i) begin
      kind_o   = addr_i[3:0];
      port_b_o = addr_i[ioxc_pkg::SPLIT_PORT_BIT];
      valid_o  = (addr_i[7:5] == 3'h0) && (addr_i[3:0] <= ioxc_pkg::SPLIT_LAST_KIND);
    end else begin
      kind_o   = addr_i[4:1];
      port_b_o = addr_i[0];
      valid_o  = (addr_i <= ioxc_pkg::PAIRED_LAST_ADDR);
    end
  end

endmodule // ioxc_addr_map

// file: rtl/ioxc_ioc_detect.sv
// Change detector of one 8-bit port: pending flag, pin flags, capture.
// Assumes pins are already synchronous to the clock.
module ioxc_ioc_detect (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  ioxc_port_if.detect port
);

  logic [7:0] prev_q;
  logic [7:0] mismatch;
  logic [7:0] hit;
  logic       pending_q;
  logic [7:0] flags_q;
  logic [7:0] capture_q;

  // ------------------------------------------------------------------
  // Compare
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= ioxc_pkg::RST_BYTE;
    end else begin
      prev_q <= port.pins;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mismatch[i] = port.source[i] ? (port.pins[i] != port.dflt[i])
                                   : (port.pins[i] != prev_q[i]);
    end
    hit = mismatch & port.enable & port.is_input;
  end

  // ------------------------------------------------------------------
  // Pending state; a new hit wins over a clearing read
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending_q <= 1'b0;
      flags_q   <= ioxc_pkg::RST_BYTE;
      capture_q <= ioxc_pkg::RST_BYTE;
    end else if (|hit) begin
      pending_q <= 1'b1;
      flags_q   <= port.clear ? hit : (flags_q | hit);
      if (!pending_q || port.clear) begin
        capture_q <= port.pins;
      end
    end else if (port.clear) begin
      pending_q <= 1'b0;
      flags_q   <= ioxc_pkg::RST_BYTE;
    end
  end

  assign port.irq     = pending_q;
  assign port.flags   = flags_q;
  assign port.capture = capture_q;

endmodule // ioxc_ioc_detect

// file: rtl/ioxc_bank.sv
// Change-interrupt control and device configuration registers of a 16-bit expander.
// Assumes a protocol engine that loads the pointer and moves single bytes.
module ioxc_bank (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Byte port from the protocol engine
  input  wire logic       ptr_load_i,
  input  wire logic [7:0] ptr_value_i,
  input  wire logic       wr_strobe_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_strobe_i,
  output logic [7:0]      rd_data_o,
  output logic            rd_valid_o,
  // Registers held outside this bank
  output logic            reg_valid_o,
  output logic [3:0]      reg_kind_o,
  output logic            reg_port_b_o,
  output logic            ext_wr_o,
  input  wire logic [7:0] ext_rd_data_i,
  // Port state
  input  wire logic [7:0] port_a_pins_i,
  input  wire logic [7:0] port_b_pins_i,
  input  wire logic [7:0] port_a_is_input_i,
  input  wire logic [7:0] port_b_is_input_i,
  // Device address and pad control
  input  wire logic       spi_variant_i,
  input  wire logic [2:0] addr_pins_i,
  output logic [2:0]      dev_addr_o,
  output logic            sda_edge_control_off_o,
  output logic [1:0]      irq_pins_out_o,
  output logic [1:0]      irq_pins_oe_o,
  output logic [7:0]      ptr_o
);

  logic [7:0] ptr_q;
  logic [7:0] cfg_q;
  logic [7:0] en_q   [2];
  logic [7:0] dflt_q [2];
  logic [7:0] src_q  [2];
  logic [7:0] rd_data_q;
  logic       rd_valid_q;
  logic [1:0] irq_out_q;
  logic [1:0] irq_oe_q;
  logic [2:0] dev_addr_q;
  logic       slew_off_q;
  logic       map_valid;
  logic [3:0] map_kind;
  logic       map_port_b;
  logic       access;
  logic [1:0] port_irq;
  logic [1:0] pin_active;
  logic [7:0] port_flags [2];
  logic [7:0] port_capture [2];
  logic [7:0] rd_mux;
  logic [7:0] pins_sel   [2];
  logic [7:0] input_sel  [2];

  assign pins_sel[0]  = port_a_pins_i;
  assign pins_sel[1]  = port_b_pins_i;
  assign input_sel[0] = port_a_is_input_i;
  assign input_sel[1] = port_b_is_input_i;

  // ------------------------------------------------------------------
  // Address decode against the live map
  // ------------------------------------------------------------------
  ioxc_addr_map u_map (
    .addr_i       (ptr_q),
    .bank_split_i (cfg_q[ioxc_pkg::CFG_BANK_SPLIT]),
    .valid_o      (map_valid),
    .kind_o       (map_kind),
    .port_b_o     (map_port_b)
  );

  assign access = wr_strobe_i || rd_strobe_i;

  // ------------------------------------------------------------------
  // Address pointer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= ioxc_pkg::RST_PTR;
    end else if (ptr_load_i) begin
      ptr_q <= ptr_value_i;
    end else if (access && !cfg_q[ioxc_pkg::CFG_PTR_HOLD]) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Configuration register, shared by both ports
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= ioxc_pkg::RST_BYTE;
    end else if (wr_strobe_i && map_valid && map_kind == ioxc_pkg::REG_CONFIG) begin
      cfg_q <= wr_data_i & ioxc_pkg::CFG_WRITE_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Per-port registers and change detectors
  // ------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    ioxc_port_if pif ();
    logic hit_port;

    assign hit_port = map_valid && (map_port_b == 1'(p));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        en_q[p]   <= ioxc_pkg::RST_BYTE;
        dflt_q[p] <= ioxc_pkg::RST_BYTE;
        src_q[p]  <= ioxc_pkg::RST_BYTE;
      end else if (wr_strobe_i && hit_port) begin
        if (map_kind == ioxc_pkg::REG_IRQ_EN) begin
          en_q[p] <= wr_data_i;
        end
        if (map_kind == ioxc_pkg::REG_DEFAULT) begin
          dflt_q[p] <= wr_data_i;
        end
        if (map_kind == ioxc_pkg::REG_SOURCE) begin
          src_q[p] <= wr_data_i;
        end
      end
    end

    assign pif.enable   = en_q[p];
    assign pif.dflt     = dflt_q[p];
    assign pif.source   = src_q[p];
    assign pif.is_input = input_sel[p];
    assign pif.pins     = pins_sel[p];
    assign pif.clear    = rd_strobe_i && hit_port
                          && (map_kind == ioxc_pkg::REG_PORT
                              || map_kind == ioxc_pkg::REG_CAPTURE);

    assign port_irq[p]     = pif.irq;
    assign port_flags[p]   = pif.flags;
    assign port_capture[p] = pif.capture;

    ioxc_ioc_detect u_detect (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .port      (pif.detect)
    );

    // Interrupt pad of this port
    assign pin_active[p] = cfg_q[ioxc_pkg::CFG_MIRROR] ? (|port_irq)
                                                       : port_irq[p];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        irq_out_q[p] <= ioxc_pkg::RST_IRQ;
        irq_oe_q[p]  <= ioxc_pkg::RST_IRQ_OE;
      end else if (cfg_q[ioxc_pkg::CFG_OPEN_DRAIN]) begin
        irq_out_q[p] <= 1'b0;
        irq_oe_q[p]  <= pin_active[p];
      end else begin
        irq_out_q[p] <= cfg_q[ioxc_pkg::CFG_ACTIVE_HIGH] ? pin_active[p]
                                                         : !pin_active[p];
        irq_oe_q[p]  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    rd_mux = ioxc_pkg::RST_BYTE;
    if (map_valid) begin
      unique case (map_kind)
        ioxc_pkg::REG_IRQ_EN:  rd_mux = en_q[map_port_b];
        ioxc_pkg::REG_DEFAULT: rd_mux = dflt_q[map_port_b];
        ioxc_pkg::REG_SOURCE:  rd_mux = src_q[map_port_b];
        ioxc_pkg::REG_CONFIG:  rd_mux = cfg_q & ioxc_pkg::CFG_WRITE_MASK;
        ioxc_pkg::REG_FLAG:    rd_mux = port_flags[map_port_b];
        ioxc_pkg::REG_CAPTURE: rd_mux = port_capture[map_port_b];
        default:               rd_mux = ext_rd_data_i;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_q  <= ioxc_pkg::RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_strobe_i;
      if (rd_strobe_i) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Device address and data pad control
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dev_addr_q <= ioxc_pkg::RST_ADDR;
      slew_off_q <= 1'b0;
    end else begin
      dev_addr_q <= (spi_variant_i && !cfg_q[ioxc_pkg::CFG_HW_ADDR_EN])
                    ? ioxc_pkg::RST_ADDR : addr_pins_i;
      slew_off_q <= cfg_q[ioxc_pkg::CFG_SLEW_OFF];
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rd_data_o              = rd_data_q;
  assign rd_valid_o             = rd_valid_q;
  assign reg_valid_o            = map_valid;
  assign reg_kind_o             = map_kind;
  assign reg_port_b_o           = map_port_b;
  assign ext_wr_o               = wr_strobe_i && map_valid
                                  && map_kind != ioxc_pkg::REG_IRQ_EN
                                  && map_kind != ioxc_pkg::REG_DEFAULT
                                  && map_kind != ioxc_pkg::REG_SOURCE
                                  && map_kind != ioxc_pkg::REG_CONFIG;
  assign dev_addr_o             = dev_addr_q;
  assign sda_edge_control_off_o = slew_off_q;
  assign irq_pins_out_o         = irq_out_q;
  assign irq_pins_oe_o          = irq_oe_q;
  assign ptr_o                  = ptr_q;

endmodule // ioxc_bank

// file: test/ioxc_bank_props.sv
// Checker of the change-interrupt and configuration bank.
// Assumes it is bound to ioxc_bank and sees only its ports.
module ioxc_bank_props (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       ptr_load_i,
  input wire logic [7:0] ptr_value_i,
  input wire logic       wr_strobe_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       rd_strobe_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       reg_valid_o,
  input wire logic [3:0] reg_kind_o,
  input wire logic       spi_variant_i,
  input wire logic [2:0] addr_pins_i,
  input wire logic [2:0] dev_addr_o,
  input wire logic       sda_edge_control_off_o,
  input wire logic [1:0] irq_pins_out_o,
  input wire logic [1:0] irq_pins_oe_o,
  input wire logic [7:0] ptr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] cfg_q;
  logic [1:0] age_q;
  logic       step;
  logic       map_ok;
  assign step   = (wr_strobe_i | rd_strobe_i) & ~ptr_load_i;
  assign map_ok = cfg_q[7] ? (ptr_o[7:5] == 3'h0 && ptr_o[3:0] <= 4'hA) : (ptr_o <= 8'h15);
  // Shadow of the configuration register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= 8'h00;
    end else if (step && wr_strobe_i && reg_valid_o && reg_kind_o == ioxc_pkg::REG_CONFIG) begin
      cfg_q <= wr_data_i & 8'hFE;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  sequence cfg_still;
    age_q == 2'h3 && $stable(cfg_q) ##1 $stable(cfg_q);
  endsequence
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_cfg_readback: assert property (
    step && rd_strobe_i && reg_valid_o && reg_kind_o == ioxc_pkg::REG_CONFIG
    |=> rd_valid_o && rd_data_o == $past(cfg_q)) else $error("config read mismatch");
  a_invalid_read: assert property (step && rd_strobe_i && !reg_valid_o |=> rd_data_o == 8'h00)
    else $error("invalid read not zero");
  a_map_decode: assert property (reg_valid_o == map_ok) else $error("address map wrong");
  a_ptr_advance: assert property (
    step && !cfg_q[5] ##1 !cfg_q[5] |-> ptr_o == $past(ptr_o) + 8'h01)
    else $error("pointer did not advance");
  a_ptr_hold: assert property (step && cfg_q[5] ##1 cfg_q[5] |-> $stable(ptr_o))
    else $error("held pointer moved");
  a_ptr_load: assert property (ptr_load_i |=> ptr_o == $past(ptr_value_i))
    else $error("pointer load wrong");
  a_slew_follow: assert property (cfg_still |-> sda_edge_control_off_o == cfg_q[4])
    else $error("slew control wrong");
  a_addr_select: assert property (
    cfg_still ##0 ($stable(addr_pins_i) && $stable(spi_variant_i))
    |-> dev_addr_o == ((spi_variant_i && !cfg_q[3]) ? 3'h0 : addr_pins_i))
    else $error("device address wrong");
  a_push_pull: assert property (cfg_still ##0 !cfg_q[2] |-> irq_pins_oe_o == 2'h3)
    else $error("push-pull not driven");
  a_open_drain: assert property (cfg_still ##0 cfg_q[2] |-> irq_pins_out_o == 2'h0)
    else $error("open-drain drives high");
  a_mirror_pair: assert property (
    cfg_still ##0 cfg_q[6] |-> irq_pins_out_o[0] == irq_pins_out_o[1])
    else $error("mirrored pins differ");
  c_split_map: cover property (cfg_q[7] && reg_valid_o);
  c_held_step: cover property (step && cfg_q[5]);
  c_mirror_hit: cover property (cfg_q[6] && irq_pins_out_o == 2'h0);
endmodule // ioxc_bank_props

bind ioxc_bank ioxc_bank_props i_props (.clk_i, .reset_n_i, .ptr_load_i, .ptr_value_i,
  .wr_strobe_i, .wr_data_i, .rd_strobe_i, .rd_data_o, .rd_valid_o, .reg_valid_o, .reg_kind_o,
  .spi_variant_i, .addr_pins_i, .dev_addr_o, .sda_edge_control_off_o, .irq_pins_out_o,
  .irq_pins_oe_o, .ptr_o);

// file: test/ioxc_host_model.sv
// Host controller model: loads the pointer and moves single bytes.
// Assumes one caller, all changes on falling edges.
module ioxc_host_model (
  input  wire logic       clk_i,
  output logic            ptr_load_o,
  output logic [7:0]      ptr_value_o,
  output logic            wr_strobe_o,
  output logic [7:0]      wr_data_o,
  output logic            rd_strobe_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ptr_load_o  = 1'b0;
    ptr_value_o = 8'h00;
    wr_strobe_o = 1'b0;
    wr_data_o   = 8'h00;
    rd_strobe_o = 1'b0;
  end
  // Released buses show a stale inverse
  task automatic put_ptr(input logic [7:0] a);
    @(negedge clk_i);
    ptr_value_o = a;
    ptr_load_o  = 1'b1;
    @(negedge clk_i);
    ptr_load_o  = 1'b0;
    ptr_value_o = ~a;
  endtask
  // Single bytes only, also for map changes
  task automatic put_byte(input logic [7:0] d);
    @(negedge clk_i);
    wr_data_o   = d;
    wr_strobe_o = 1'b1;
    @(negedge clk_i);
    wr_strobe_o = 1'b0;
    wr_data_o   = ~d;
  endtask
  task automatic get_byte(output logic [7:0] d, output logic v);
    @(negedge clk_i);
    rd_strobe_o = 1'b1;
    @(negedge clk_i);
    rd_strobe_o = 1'b0;
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule // ioxc_host_model

// file: test/ioxc_bank_bench.sv
// Self-checking bench of the change-interrupt and configuration bank.
// Assumes the host model and the bound checker.
module ioxc_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       ptr_load, wr_strobe, rd_strobe, rd_valid, reg_vld, sda_off;
  logic       spi = 1'b0;
  logic [7:0] ptr_value, wr_data, rd_data, ptr;
  logic [7:0] pa = 8'h00, pb = 8'h00, ia = 8'hFF, ib = 8'hFF;
  logic [2:0] addr_pins = 3'h5, dev_addr;
  logic [1:0] irq_out, irq_oe;
  logic [7:0] ext = 8'h3C;
  logic [3:0] kind;
  logic       port_b, ext_wr;
  int         ext_wr_seen = 0;
  int         fail_count = 0;
  int         tests_run = 0;
  int         cycles = 0;
  always #2.5 clk_i = ~clk_i;
  ioxc_host_model i_host (.clk_i(clk_i), .ptr_load_o(ptr_load), .ptr_value_o(ptr_value),
    .wr_strobe_o(wr_strobe), .wr_data_o(wr_data), .rd_strobe_o(rd_strobe),
    .rd_data_i(rd_data), .rd_valid_i(rd_valid));
  ioxc_bank i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ptr_load_i(ptr_load),
    .ptr_value_i(ptr_value), .wr_strobe_i(wr_strobe), .wr_data_i(wr_data),
    .rd_strobe_i(rd_strobe), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .reg_valid_o(reg_vld),
    .reg_kind_o(kind), .reg_port_b_o(port_b), .ext_wr_o(ext_wr), .ext_rd_data_i(ext),
    .port_a_pins_i(pa), .port_b_pins_i(pb), .port_a_is_input_i(ia), .port_b_is_input_i(ib),
    .spi_variant_i(spi), .addr_pins_i(addr_pins), .dev_addr_o(dev_addr),
    .sda_edge_control_off_o(sda_off), .irq_pins_out_o(irq_out), .irq_pins_oe_o(irq_oe),
    .ptr_o(ptr));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.get_byte(d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk(what, exp, d);
  endtask
  task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
    i_host.put_ptr(a);
    i_host.put_byte(d);
  endtask
  task automatic do_reset;
    @(negedge clk_i);
    reset_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
  endtask
  task automatic wait_chk(input logic [1:0] exp);
    repeat (2) @(negedge clk_i);
    chk("irq pins", {6'h00, exp}, {6'h00, irq_out});
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_rw_regs;
    i_host.put_ptr(8'h04);
    for (int i = 1; i < 7; i++) i_host.put_byte(8'(8'h11 * i));
    i_host.put_ptr(8'h04);
    for (int i = 1; i < 7; i++) rd_chk("control reg", 8'(8'h11 * i));
    $display("done read-write");
  endtask
  task automatic t_reset_values;
    i_host.put_ptr(8'h04);
    for (int i = 0; i < 8; i++) rd_chk("reset value", 8'h00);
    $display("done reset values");
  endtask
  task automatic t_ptr_hold;
    wr_at(8'h0A, 8'h21);
    i_host.put_ptr(8'h04);
    i_host.put_byte(8'h5A);
    i_host.put_byte(8'hA5);
    chk("held ptr", 8'h04, ptr);
    rd_chk("held reg", 8'hA5);
    wr_at(8'h0A, 8'h00);
    rd_chk("config", 8'h00);
    $display("done pointer hold");
  endtask
  task automatic t_bank_switch;
    wr_at(8'h0A, 8'h80);
    chk("ptr after switch", 8'h0B, ptr);
    chk("valid", 8'h00, {7'h00, reg_vld});
    rd_chk("invalid read", 8'h00);
    i_host.put_ptr(8'h15);
    rd_chk("split config", 8'h80);
    i_host.put_ptr(8'h1A);
    chk("valid 1A", 8'h01, {7'h00, reg_vld});
    i_host.put_ptr(8'h1B);
    chk("valid 1B", 8'h00, {7'h00, reg_vld});
    wr_at(8'h05, 8'h00);
    chk("valid 06", 8'h01, {7'h00, reg_vld});
    i_host.put_ptr(8'h16);
    chk("valid 16", 8'h00, {7'h00, reg_vld});
    $display("done bank switch");
  endtask
  task automatic t_irq;
    logic [7:0] d;
    logic       v;
    i_host.put_ptr(8'h04);
    i_host.put_byte(8'h01);
    i_host.put_byte(8'h01);
    i_host.put_byte(8'h00);
    i_host.put_byte(8'h00);
    i_host.put_byte(8'h01);
    i_host.put_byte(8'h00);
    i_host.put_ptr(8'h10);
    i_host.get_byte(d, v);
    i_host.get_byte(d, v);
    wait_chk(2'h3);
    pa = 8'h01;
    wait_chk(2'h2);
    pa = 8'h00;
    i_host.put_ptr(8'h12);
    i_host.get_byte(d, v);
    wait_chk(2'h3);
    pb = 8'h01;
    wait_chk(2'h1);
    i_host.put_ptr(8'h11);
    i_host.get_byte(d, v);
    wait_chk(2'h3);
    ia = 8'hFE;
    pa = 8'h01;
    wait_chk(2'h3);
    ia = 8'hFF;
    pa = 8'h02;
    wait_chk(2'h3);
    pa = 8'h00;
    wr_at(8'h0A, 8'h40);
    pb = 8'h00;
    wait_chk(2'h0);
    i_host.put_ptr(8'h11);
    i_host.get_byte(d, v);
    wait_chk(2'h3);
    wr_at(8'h0A, 8'h42);
    wait_chk(2'h0);
    wr_at(8'h0A, 8'h44);
    pa = 8'h01;
    wait_chk(2'h0);
    chk("irq oe", 8'h03, {6'h00, irq_oe});
    pa = 8'h00;
    i_host.put_ptr(8'h12);
    i_host.get_byte(d, v);
    wait_chk(2'h0);
    chk("irq oe idle", 8'h00, {6'h00, irq_oe});
    $display("done interrupts");
  endtask
  task automatic t_cfg_pins;
    spi = 1'b1;
    wr_at(8'h0A, 8'h18);
    repeat (2) @(negedge clk_i);
    chk("slew off", 8'h01, {7'h00, sda_off});
    chk("dev addr", 8'h05, {5'h00, dev_addr});
    wr_at(8'h0A, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("slew on", 8'h00, {7'h00, sda_off});
    chk("dev addr", 8'h00, {5'h00, dev_addr});
    spi = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("dev addr", 8'h05, {5'h00, dev_addr});
    addr_pins = 3'h2;
    repeat (2) @(negedge clk_i);
    chk("dev addr pins", 8'h02, {5'h00, dev_addr});
    $display("done config pins");
  endtask
  task automatic t_ext_path;
    int n;
    n = ext_wr_seen;
    i_host.put_ptr(8'h13);
    chk("kind 13", 8'h09, {4'h0, kind});
    chk("port b 13", 8'h01, {7'h00, port_b});
    rd_chk("ext read", 8'h3C);
    ext = 8'hC3;
    i_host.put_ptr(8'h14);
    rd_chk("ext read 14", 8'hC3);
    i_host.put_ptr(8'h14);
    i_host.put_byte(8'h5A);
    i_host.put_ptr(8'h04);
    i_host.put_byte(8'h01);
    i_host.put_ptr(8'h16);
    i_host.put_byte(8'h5A);
    chk("ext writes", 8'h01, 8'(ext_wr_seen - n));
    ib = 8'hFE;
    pb = 8'h01;
    wait_chk(2'h3);
    ib = 8'hFF;
    wait_chk(2'h3);
    $display("done external path");
  endtask
  always @(posedge clk_i) begin
    if (ext_wr) begin
      ext_wr_seen++;
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    do_reset();
    t_rw_regs();
    do_reset();
    t_reset_values();
    t_ptr_hold();
    t_bank_switch();
    t_irq();
    t_cfg_pins();
    t_ext_path();
    end_of_test();
  end
endmodule // ioxc_bank_bench
